// File: i2cf_pkg.sv
`default_nettype none
package i2cf_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_OWN = 8'h08;
  localparam logic [7:0] OFF_ISTAT = 8'h0C;
  localparam logic [7:0] OFF_IMASK = 8'h10;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_EN = 7;
  localparam int CTRL_EXIT = 6;
  localparam int CTRL_WREL = 5;
  localparam int STAT_MATCH = 4;
  localparam int STAT_TRC = 3;
  localparam int IRQ_W = 3;
  localparam int EV_MATCH = 0;
  localparam int EV_START = 1;
  localparam int EV_STOP = 2;
  // ---------------------------------------------------------------
  // serial clock counts and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_SEVENTH = 4'h7;
  localparam logic [3:0] CNT_NINTH = 4'h9;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] OWN_RESET = 8'h00;
endpackage
`default_nettype wire

// File: i2cf_flags.sv
// Overview of operation
// - set address match at eighth serial clock rise when address equals own address
// - clear match on start, stop, exit write, enable falling, reset
// - direction flag zero: data line released, not driven
// - direction flag one: drive output latch, slave from first byte ninth fall
// - clear direction on stop, exit, enable falling, reset, arbitration lost rising
// - master: set direction on start generated or sent 0, clear on sent 1
// - slave: clear direction on start or received 0, set on received 1
// - wait release at ninth clock while transmitting clears direction, releases line
// - exit command is control bit 6, operation enable is control bit 7
// - bus status register resets to all zeros
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module i2cf_flags
  import i2cf_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // neighbouring controller logic
  input wire logic master_mode,
  input wire logic start_generated,
  input wire logic arbitration_lost_flag,
  input wire logic shift_output_latch,
  // i2c pins
  input wire logic scl_in,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  // interrupt
  output logic irq
);
  import i2cf_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    logic [3:0] bit_cnt;
    logic first_byte;
    logic [7:0] shift;
    logic match;
    logic trc;
    logic slave_drive;
    logic enable;
    logic enable_p;
    logic arb_p;
    logic [7:0] own_addr;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic sda_out;
    logic sda_oe;
  } i2cf_state_type;

  i2cf_state_type st_q;
  i2cf_state_type st_d;

  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic acc;
  logic wr_ctrl;
  logic exit_cmd;
  logic wrel_cmd;
  logic enable_fall;
  logic arb_rise;
  logic byte_done;
  logic dir_bit;
  logic addr_hit;
  logic [7:0] rx_byte;

  // ---------------------------------------------------------------
  // bus conditions, seen only after the second sync flop
  // ---------------------------------------------------------------
  assign start_det = st_q.scl_s2 & st_q.scl_p & st_q.sda_p & ~st_q.sda_s2;
  assign stop_det = st_q.scl_s2 & st_q.scl_p & ~st_q.sda_p & st_q.sda_s2;
  assign scl_rise = st_q.scl_s2 & ~st_q.scl_p;
  assign scl_fall = ~st_q.scl_s2 & st_q.scl_p;
  assign acc = psel & penable & ~st_q.pready;
  assign wr_ctrl = acc & pwrite & (paddr == OFF_CTRL);
  assign exit_cmd = wr_ctrl & pwdata[CTRL_EXIT];
  assign wrel_cmd = wr_ctrl & pwdata[CTRL_WREL];
  assign enable_fall = st_q.enable_p & ~st_q.enable;
  assign arb_rise = arbitration_lost_flag & ~st_q.arb_p;
  // eighth rise of the first byte: count goes from seven to eight
  assign byte_done = scl_rise & st_q.first_byte & (st_q.bit_cnt == CNT_SEVENTH);
  assign rx_byte = {st_q.shift[6:0], st_q.sda_s2};
  assign dir_bit = st_q.sda_s2;
  assign addr_hit = rx_byte[7:1] == st_q.own_addr[7:1];

  always_comb
  begin
    st_d = st_q;
    st_d.scl_s1 = scl_in;
    st_d.scl_s2 = st_q.scl_s1;
    st_d.scl_p = st_q.scl_s2;
    st_d.sda_s1 = serial_data_pin_in;
    st_d.sda_s2 = st_q.sda_s1;
    st_d.sda_p = st_q.sda_s2;
    st_d.enable_p = st_q.enable;
    st_d.arb_p = arbitration_lost_flag;

    // -------------------------------------------------------------
    // serial clock counting
    // -------------------------------------------------------------
    if (start_det)
    begin
      st_d.bit_cnt = CNT_ZERO;
      st_d.first_byte = 1'b1;
      st_d.slave_drive = 1'b0;
    end
    else if (scl_rise && st_q.bit_cnt < CNT_NINTH)
    begin
      st_d.bit_cnt = st_q.bit_cnt + CNT_ONE;
      st_d.shift = rx_byte;
    end
    else if (scl_fall && st_q.bit_cnt == CNT_NINTH)
    begin
      st_d.bit_cnt = CNT_ZERO;
      st_d.first_byte = 1'b0;
      // slave output starts at the ninth fall of the first byte
      if (st_q.first_byte)
        st_d.slave_drive = 1'b1;
    end
    if (stop_det)
      st_d.slave_drive = 1'b0;

    // -------------------------------------------------------------
    // address match flag
    // -------------------------------------------------------------
    if (start_det || stop_det || exit_cmd || enable_fall)
      st_d.match = 1'b0;
    else if (byte_done && addr_hit && st_q.enable)
      st_d.match = 1'b1;

    // -------------------------------------------------------------
    // direction flag; common clears override role events
    // -------------------------------------------------------------
    if (master_mode)
    begin
      if (start_generated && st_q.enable)
        st_d.trc = 1'b1;
      else if (byte_done)
        st_d.trc = ~dir_bit & st_q.enable;
    end
    else
    begin
      if (start_det)
        st_d.trc = 1'b0;
      else if (byte_done)
        st_d.trc = dir_bit & st_q.enable;
    end
    if (wrel_cmd && st_q.trc && st_q.bit_cnt == CNT_NINTH)
      st_d.trc = 1'b0;
    if (stop_det || exit_cmd || enable_fall || arb_rise)
      st_d.trc = 1'b0;

    // registered pin drive; receive status keeps the line released
    st_d.sda_out = shift_output_latch;
    st_d.sda_oe = st_d.trc & (master_mode | st_d.slave_drive);

    // -------------------------------------------------------------
    // apb: one wait state, answer in second access cycle
    // -------------------------------------------------------------
    st_d.pready = acc;
    st_d.pslverr = 1'b0;
    if (acc)
    begin
      st_d.prdata = '0;
      if (paddr == OFF_CTRL)
      begin
        // command bits are pulses and read back as zero
        st_d.prdata[CTRL_EN] = st_q.enable;
        if (pwrite)
          st_d.enable = pwdata[CTRL_EN];
      end
      else if (paddr == OFF_STAT)
      begin
        st_d.prdata[STAT_MATCH] = st_q.match;
        st_d.prdata[STAT_TRC] = st_q.trc;
      end
      else if (paddr == OFF_OWN)
      begin
        st_d.prdata[7:0] = st_q.own_addr;
        if (pwrite)
          st_d.own_addr = pwdata[7:0];
      end
      else if (paddr == OFF_ISTAT)
      begin
        st_d.prdata[IRQ_W-1:0] = st_q.istat;
        if (pwrite)
          st_d.istat = st_q.istat & ~pwdata[IRQ_W-1:0];
      end
      else if (paddr == OFF_IMASK)
      begin
        st_d.prdata[IRQ_W-1:0] = st_q.imask;
        if (pwrite)
          st_d.imask = pwdata[IRQ_W-1:0];
      end
      else
        st_d.pslverr = 1'b1;
    end

    // -------------------------------------------------------------
    // sticky events; a set in the clearing cycle is kept
    // -------------------------------------------------------------
    if (st_d.match && !st_q.match)
      st_d.istat[EV_MATCH] = 1'b1;
    if (start_det)
      st_d.istat[EV_START] = 1'b1;
    if (stop_det)
      st_d.istat[EV_STOP] = 1'b1;
    st_d.irq = |(st_d.istat & st_d.imask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
      st_q.own_addr <= OWN_RESET;
      // lines idle high; a zero here would fake an scl rise after reset
      st_q.scl_s1 <= 1'b1;
      st_q.scl_s2 <= 1'b1;
      st_q.scl_p <= 1'b1;
      st_q.sda_s1 <= 1'b1;
      st_q.sda_s2 <= 1'b1;
      st_q.sda_p <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign serial_data_pin_out = st_q.sda_out;
  assign serial_data_pin_oe = st_q.sda_oe;
  assign irq = st_q.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence addr_seen_s;
    byte_done && addr_hit && st_q.enable;
  endsequence

  sequence slave_dir1_s;
    !master_mode && byte_done && dir_bit && st_q.enable;
  endsequence

  sequence no_trc_clear_s;
    !stop_det && !exit_cmd && !enable_fall && !arb_rise;
  endsequence

  match_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    addr_seen_s ##0 (!exit_cmd && !enable_fall) |=> st_q.match && st_q.shift == $past(rx_byte))
    else $error("address match not set");

  match_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start_det || stop_det || exit_cmd || enable_fall) |=> !st_q.match)
    else $error("address match not cleared");

  rx_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st_q.trc |-> !st_q.sda_oe)
    else $error("data line driven in receive status");

  tx_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_d.trc && st_d.slave_drive) |=> st_q.sda_oe && st_q.sda_out == $past(shift_output_latch))
    else $error("latch not driven in transmit");

  trc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (stop_det || exit_cmd || enable_fall || arb_rise) |=> !st_q.trc)
    else $error("direction flag not cleared");

  mst_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (master_mode && start_generated && st_q.enable) ##0 no_trc_clear_s |=> st_q.trc)
    else $error("master start did not set direction");

  slv_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    slave_dir1_s ##0 no_trc_clear_s |=> st_q.trc)
    else $error("slave read direction not set");

  wait_rel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wrel_cmd && st_q.trc && st_q.bit_cnt == CNT_NINTH) |=> !st_q.trc ##1 !st_q.sda_oe)
    else $error("wait release kept transmit");

  enable_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> st_q.enable == $past(pwdata[CTRL_EN]))
    else $error("enable bit not taken");

  sync_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 st_q.scl_s2 == $past(scl_in, 2))
    else $error("scl not two-flop synchronised");
endmodule
`default_nettype wire

// File: nothing_more.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: i2cf_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2cf_bus_model (
  // bench clock; pin changes land on its falling edge, off the sampling edge
  input wire logic clk,
  // device side of the data wire
  input wire logic dev_out,
  input wire logic dev_oe,
  // pin levels seen by the device
  output logic scl,
  output logic sda
);
  logic drv_low;
  // open drain with pull-up: high unless either party pulls low
  assign sda = !(drv_low || (dev_oe && !dev_out));
  initial
  begin
    scl = 1'b1;
    drv_low = 1'b0;
  end
  // ---------------------------------------------------------------
  // frame pieces; scl stands still between frames
  // ---------------------------------------------------------------
  task automatic bit_c(input logic b);
    drv_low = !b;
    #100 scl = 1'b1;
    #200 scl = 1'b0;
    #100;
  endtask
  // start, eight bits msb first, then stops high in the ninth clock
  task automatic addr_byte(input logic [7:0] v);
    @(negedge clk);
    drv_low = 1'b0;
    scl = 1'b1;
    #100 drv_low = 1'b1;
    #100 scl = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--) bit_c(v[i]);
    drv_low = 1'b0;
    #100 scl = 1'b1;
    #100;
  endtask
  task automatic fall9;
    @(negedge clk);
    scl = 1'b0;
    #100;
  endtask
  task automatic stop_c;
    @(negedge clk);
    drv_low = 1'b1;
    #100 scl = 1'b1;
    #100 drv_low = 1'b0;
    #100;
  endtask
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import i2cf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic master_mode, start_generated, arb_lost, latch, scl, sda, sd_out, sd_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int err_count, n_tests;
  localparam logic [31:0] ST_M = 32'h1 << STAT_MATCH;
  localparam logic [31:0] ST_T = 32'h1 << STAT_TRC;
  localparam logic [31:0] EN = 32'h1 << CTRL_EN;
  i2cf_flags i2cf_flags_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .master_mode(master_mode), .start_generated(start_generated),
    .arbitration_lost_flag(arb_lost), .shift_output_latch(latch), .scl_in(scl),
    .serial_data_pin_in(sda), .serial_data_pin_out(sd_out), .serial_data_pin_oe(sd_oe),
    .irq(irq));
  i2cf_bus_model i2cf_bus_model_i (.clk(pclk), .dev_out(sd_out), .dev_oe(sd_oe),
    .scl(scl), .sda(sda));
  always #25 pclk = !pclk;
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; only the watchdog ends a wait that never sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  task automatic pulse_start;
    @(posedge pclk) start_generated <= 1'b1;
    @(posedge pclk) start_generated <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rd_chk(OFF_STAT, {24'h0, STATUS_RESET});
    rd_chk(OFF_OWN, {24'h0, OWN_RESET});
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    wr(OFF_OWN, 32'h54);
    wr(OFF_IMASK, 32'h1);
    wr(OFF_CTRL, EN);
  endtask
  task automatic t_slave_tx;
    i2cf_bus_model_i.addr_byte(8'h55);
    chk({31'h0, sd_oe}, 32'h0);
    rd_chk(OFF_STAT, ST_M | ST_T);
    chk({31'h0, irq}, 32'h1);
    i2cf_bus_model_i.fall9;
    @(posedge pclk) latch <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({30'h0, sd_oe, sda}, 32'h2);
    latch <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({30'h0, sd_oe, sda}, 32'h3);
    rd_chk(OFF_ISTAT, 32'h3);
    wr(OFF_ISTAT, 32'h7);
    chk({31'h0, irq}, 32'h0);
    i2cf_bus_model_i.stop_c;
    rd_chk(OFF_STAT, 32'h0);
  endtask
  task automatic t_wait_release;
    i2cf_bus_model_i.addr_byte(8'h55);
    wr(OFF_CTRL, EN | (32'h1 << CTRL_WREL));
    repeat (2) @(posedge pclk);
    chk({31'h0, sd_oe}, 32'h0);
    rd_chk(OFF_STAT, ST_M);
    i2cf_bus_model_i.fall9;
    repeat (4) @(posedge pclk);
    chk({31'h0, sd_oe}, 32'h0);
    i2cf_bus_model_i.stop_c;
  endtask
  task automatic t_slave_rx_exit;
    i2cf_bus_model_i.addr_byte(8'h54);
    rd_chk(OFF_STAT, ST_M);
    i2cf_bus_model_i.fall9;
    repeat (4) @(posedge pclk);
    chk({31'h0, sd_oe}, 32'h0);
    wr(OFF_CTRL, EN | (32'h1 << CTRL_EXIT));
    rd_chk(OFF_STAT, 32'h0);
    i2cf_bus_model_i.stop_c;
  endtask
  task automatic t_master;
    @(posedge pclk) master_mode <= 1'b1;
    pulse_start();
    rd_chk(OFF_STAT, ST_T);
    i2cf_bus_model_i.addr_byte(8'h23);
    rd_chk(OFF_STAT, 32'h0);
    i2cf_bus_model_i.fall9;
    i2cf_bus_model_i.stop_c;
    i2cf_bus_model_i.addr_byte(8'h22);
    rd_chk(OFF_STAT, ST_T);
    arb_lost <= 1'b1;
    rd_chk(OFF_STAT, 32'h0);
    arb_lost <= 1'b0;
    i2cf_bus_model_i.fall9;
    i2cf_bus_model_i.stop_c;
    pulse_start();
    wr(OFF_CTRL, 32'h0);
    rd_chk(OFF_STAT, 32'h0);
    master_mode <= 1'b0;
  endtask
  initial
  begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; master_mode = 1'b0; start_generated = 1'b0;
    arb_lost = 1'b0; latch = 1'b1; err_count = 0; n_tests = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_slave_tx();
    t_wait_release();
    t_slave_rx_exit();
    t_master();
    test_done();
  end
  // all frames together take well under this span
  initial
  begin
    #500000;
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
